// *** verilog/hscl_strap_config.sv ***
// Summary of operation
// - capture all straps at reset release and rise
// - d-plus strap: 0 enabled, 1 disables only with d-minus also 1
// - d-minus strap: 0 enabled, 1 disables only with d-plus also 1
// - straps disable a port only when both are high
// - disabling 2.0 path also disables 3.0 path
// - non-removable strap decodes six levels
// - report that many ports as non-removable
// - charging strap sets charging-enabled port count
// - three mode straps select operating mode
// - charging strap decodes six levels to ports
`timescale 1ns/10ps
`default_nettype none
module hscl_strap_config (
  // clock and power-on reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // external reset pin, active low
  input  wire logic                             ext_reset_n,
  // strap pins
  input  wire hscl_pkg::hscl_strap_s            strap_in,
  // configuration out
  output var  hscl_pkg::hscl_cfg_s              cfg_ff,
  output logic                                  cfg_valid_ff,
  // axi4-lite write address
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [hscl_pkg::ADDR_W-1:0]      s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  input  wire logic [hscl_pkg::DATA_W-1:0]      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  // axi4-lite write response
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  output logic [1:0]                            s_axi_bresp,
  // axi4-lite read address
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  input  wire logic [hscl_pkg::ADDR_W-1:0]      s_axi_araddr,
  // axi4-lite read data
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  output logic [hscl_pkg::DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp
);
  import hscl_pkg::*;

  logic                   por_seen_ff;
  logic                   ext_q_ff;
  logic                   capture_ff;
  logic                   nxt_capture;
  logic                   cap_d1_ff;
  logic                   cap_d2_ff;
  hscl_strap_s            latched;
  logic [NUM_PORTS-1:0]   nonrem_mask;
  logic [NUM_PORTS-1:0]   charge_mask;
  logic [NUM_PORTS-1:0]   sw_dis_ff;
  logic [NUM_PORTS-1:0]   strap_dis;

  logic                   awready_ff;
  logic                   wready_ff;
  logic                   aw_have_ff;
  logic                   w_have_ff;
  logic [ADDR_W-1:0]      awaddr_ff;
  logic [DATA_W-1:0]      wdata_ff;
  logic [3:0]             wstrb_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   arready_ff;
  logic                   rvalid_ff;
  logic [DATA_W-1:0]      rdata_ff;
  logic [1:0]             rresp_ff;
  logic                   wr_commit;
  logic [ADDR_W-1:0]      wr_word;

  // capture strobe: first edge after power-on release, or external pin rise
  assign nxt_capture = !por_seen_ff || (ext_reset_n && !ext_q_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_seen_ff <= 1'b0;
      ext_q_ff    <= 1'b1;
      capture_ff  <= 1'b0;
    end else begin
      por_seen_ff <= 1'b1;
      ext_q_ff    <= ext_reset_n;
      capture_ff  <= nxt_capture;
    end
  end

  // pins are assumed settled by the time the strobe fires
  hscl_strap_latch u_latch (
    .clk      (clk),
    .rst_n    (rst_n),
    .capture  (capture_ff),
    .strap_in (strap_in),
    .strap_ff (latched)
  );

  // one decoder per six-level strap
  hscl_level_decode u_nonrem_dec (
    .clk     (clk),
    .rst_n   (rst_n),
    .lvl     (latched.nonrem_lvl),
    .mask_ff (nonrem_mask)
  );

  hscl_level_decode u_charge_dec (
    .clk     (clk),
    .rst_n   (rst_n),
    .lvl     (latched.charge_lvl),
    .mask_ff (charge_mask)
  );

  // a single high strap leaves the port enabled
  assign strap_dis = latched.dplus & latched.dminus;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.port_u2_dis <= strap_dis | sw_dis_ff;
      cfg_ff.port_u3_dis <= strap_dis | sw_dis_ff;
      cfg_ff.nonrem_mask <= nonrem_mask;
      cfg_ff.charge_mask <= charge_mask;
      cfg_ff.mode        <= latched.mode;
    end
  end

  // valid drops during external reset and the decode pipeline
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_d1_ff    <= 1'b0;
      cap_d2_ff    <= 1'b0;
      cfg_valid_ff <= 1'b0;
    end else begin
      cap_d1_ff <= capture_ff;
      cap_d2_ff <= cap_d1_ff;
      if (!ext_reset_n || capture_ff) begin
        cfg_valid_ff <= 1'b0;
      end else if (cap_d2_ff) begin
        cfg_valid_ff <= 1'b1;
      end
    end
  end

  // software mask can add disabled ports but never re-enable strapped ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_dis_ff <= SW_DIS_RST;
    end else if (wr_commit && wr_word == REG_SW_DISABLE && wstrb_ff[0]) begin
      sw_dis_ff <= wdata_ff[NUM_PORTS-1:0];
    end
  end

  assign wr_commit = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_word   = {awaddr_ff[ADDR_W-1:2], 2'h0};

  // write address and data taken independently, in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_have_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_have_ff <= 1'b0;
    end else if (!aw_have_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_ff <= 1'b0;
      w_have_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_have_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_have_ff <= 1'b0;
    end else if (!w_have_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // response only after both halves; read-only words ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read: data registered on the same edge that takes the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff   <= '0;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
        REG_STRAP_PINS: begin
          rdata_ff[FLD_DPLUS_LSB +: NUM_PORTS]  <= latched.dplus;
          rdata_ff[FLD_DMINUS_LSB +: NUM_PORTS] <= latched.dminus;
          rdata_ff[FLD_PDIS_LSB +: NUM_PORTS]   <= cfg_ff.port_u2_dis;
        end
        REG_FEATURES: begin
          rdata_ff[FLD_NONREM_LSB +: NUM_PORTS] <= cfg_ff.nonrem_mask;
          rdata_ff[FLD_CHARGE_LSB +: NUM_PORTS] <= cfg_ff.charge_mask;
          rdata_ff[FLD_MODE_LSB +: MODE_W]      <= cfg_ff.mode;
        end
        REG_SW_DISABLE: begin
          rdata_ff[NUM_PORTS-1:0] <= sw_dis_ff;
        end
        REG_STATUS: begin
          rdata_ff[FLD_VALID_BIT] <= cfg_valid_ff;
        end
        default: begin
          rdata_ff <= '0;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_CAPTURE_AT_POR:
    assert property ($rose(por_seen_ff) |-> capture_ff)
    else $error("no capture after power-on release");

  AST_CAPTURE_AT_EXT_RISE:
    assert property (ext_reset_n && !ext_q_ff |=> capture_ff ##1 (latched == $past(strap_in)))
    else $error("straps not captured on external reset rise");

  AST_VALID_AFTER_PIPE:
    assert property (capture_ff ##1 (ext_reset_n && !capture_ff)[*3] |-> cfg_valid_ff)
    else $error("config not valid three edges after capture");

  AST_BOTH_STRAPS_DISABLE:
    assert property (cfg_valid_ff && $past(sw_dis_ff) == SW_DIS_RST |->
                     cfg_ff.port_u2_dis == (latched.dplus & latched.dminus))
    else $error("port disable does not match both straps");

  AST_U3_FOLLOWS_U2:
    assert property (cfg_ff.port_u3_dis == cfg_ff.port_u2_dis)
    else $error("3.0 path disable differs from 2.0 path");

  AST_NONREM_DECODE:
    assert property (cfg_valid_ff |-> cfg_ff.nonrem_mask == lvl_to_mask(latched.nonrem_lvl))
    else $error("non-removable mask does not match strap level");

  AST_CHARGE_DECODE:
    assert property (cfg_valid_ff |-> cfg_ff.charge_mask == lvl_to_mask(latched.charge_lvl))
    else $error("charging mask does not match strap level");

  AST_MODE_FOLLOWS:
    assert property (cfg_valid_ff |-> cfg_ff.mode == latched.mode)
    else $error("mode does not match latched straps");

  AST_HELD_WITHOUT_CAPTURE:
    assert property (!capture_ff |=> $stable(latched))
    else $error("latched straps changed without capture");

  AST_TOP_LEVEL_ALL:
    assert property (cfg_valid_ff && latched.nonrem_lvl == LVL_PU_STRONG |-> cfg_ff.nonrem_mask == MASK_P1_6)
    else $error("strongest pull-up does not mark all ports");

endmodule : hscl_strap_config
`default_nettype wire

// *** verilog/hscl_pkg.sv ***
`default_nettype none
package hscl_pkg;

  // widths
  localparam int NUM_PORTS = 6;
  localparam int LVL_W     = 3;
  localparam int MODE_W    = 3;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // six strap levels, weakest pull-down to strongest pull-up
  localparam logic [LVL_W-1:0] LVL_PD_WEAK   = 3'h0;
  localparam logic [LVL_W-1:0] LVL_PU_WEAK   = 3'h1;
  localparam logic [LVL_W-1:0] LVL_PD_MID    = 3'h2;
  localparam logic [LVL_W-1:0] LVL_PU_MID    = 3'h3;
  localparam logic [LVL_W-1:0] LVL_PD_STRONG = 3'h4;
  localparam logic [LVL_W-1:0] LVL_PU_STRONG = 3'h5;

  // port masks, bit 0 is port 1
  localparam logic [NUM_PORTS-1:0] MASK_NONE  = 6'h00;
  localparam logic [NUM_PORTS-1:0] MASK_P1    = 6'h01;
  localparam logic [NUM_PORTS-1:0] MASK_P1_2  = 6'h03;
  localparam logic [NUM_PORTS-1:0] MASK_P1_3  = 6'h07;
  localparam logic [NUM_PORTS-1:0] MASK_P1_4  = 6'h0F;
  localparam logic [NUM_PORTS-1:0] MASK_P1_6  = 6'h3F;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_STRAP_PINS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FEATURES   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SW_DISABLE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h0C;

  // field positions
  localparam int FLD_DPLUS_LSB  = 0;
  localparam int FLD_DMINUS_LSB = 8;
  localparam int FLD_PDIS_LSB   = 16;
  localparam int FLD_NONREM_LSB = 0;
  localparam int FLD_CHARGE_LSB = 8;
  localparam int FLD_MODE_LSB   = 16;
  localparam int FLD_VALID_BIT  = 0;

  // reset values and timing
  localparam logic [NUM_PORTS-1:0] SW_DIS_RST   = 6'h00;
  localparam int                   CAP_TO_VALID = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [NUM_PORTS-1:0] dplus;
    logic [NUM_PORTS-1:0] dminus;
    logic [LVL_W-1:0]     nonrem_lvl;
    logic [LVL_W-1:0]     charge_lvl;
    logic [MODE_W-1:0]    mode;
  } hscl_strap_s;

  typedef struct packed {
    logic [NUM_PORTS-1:0] port_u2_dis;
    logic [NUM_PORTS-1:0] port_u3_dis;
    logic [NUM_PORTS-1:0] nonrem_mask;
    logic [NUM_PORTS-1:0] charge_mask;
    logic [MODE_W-1:0]    mode;
  } hscl_cfg_s;

  // reserved levels decode to no ports
  function automatic logic [NUM_PORTS-1:0] lvl_to_mask(input logic [LVL_W-1:0] lvl);
    case (lvl)
      LVL_PD_WEAK:   lvl_to_mask = MASK_NONE;
      LVL_PU_WEAK:   lvl_to_mask = MASK_P1;
      LVL_PD_MID:    lvl_to_mask = MASK_P1_2;
      LVL_PU_MID:    lvl_to_mask = MASK_P1_3;
      LVL_PD_STRONG: lvl_to_mask = MASK_P1_4;
      LVL_PU_STRONG: lvl_to_mask = MASK_P1_6;
      default:       lvl_to_mask = MASK_NONE;
    endcase
  endfunction : lvl_to_mask

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'h0};
    is_mapped = (a == REG_STRAP_PINS) || (a == REG_FEATURES) ||
                (a == REG_SW_DISABLE) || (a == REG_STATUS);
  endfunction : is_mapped

endpackage : hscl_pkg
`default_nettype wire

// *** verilog/hscl_strap_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
module hscl_strap_latch (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // capture strobe and pins
  input  wire logic                 capture,
  input  wire hscl_pkg::hscl_strap_s strap_in,
  // held values
  output var  hscl_pkg::hscl_strap_s strap_ff
);
  import hscl_pkg::*;

  // pins are ignored outside the capture strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ff <= '0;
    end else if (capture) begin
      strap_ff <= strap_in;
    end
  end

endmodule : hscl_strap_latch
`default_nettype wire

// *** verilog/hscl_level_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module hscl_level_decode (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // latched level code
  input  wire logic [hscl_pkg::LVL_W-1:0]      lvl,
  // decoded port mask
  output logic      [hscl_pkg::NUM_PORTS-1:0]  mask_ff
);
  import hscl_pkg::*;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= MASK_NONE;
    end else begin
      mask_ff <= lvl_to_mask(lvl);
    end
  end

endmodule : hscl_level_decode
`default_nettype wire

// *** verification/hscl_board_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module hscl_board_model (
  // clock and power-on reset
  input  wire logic                  clk,
  input  wire logic                  por_n,
  // bench requests
  input  wire logic                  pulse,
  input  wire logic                  glitch,
  input  wire hscl_pkg::hscl_strap_s want,
  // pins seen by the device
  output var  hscl_pkg::hscl_strap_s strap_in,
  output var  logic                  ext_reset_n
);
  import hscl_pkg::*;
  // on-chip firmware, so every strap resistor is fitted
  localparam bit EXT_FW = 1'b0;
  hscl_strap_s held;
  int          cnt;
  initial begin
    ext_reset_n = 1'b1;
    cnt         = 0;
  end
  // reset source: five cycles low per request
  always @(posedge clk) begin
    if (pulse && cnt == 0) begin
      ext_reset_n <= 1'b0;
      cnt         <= 5;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt         <= 0;
      ext_reset_n <= 1'b1;
    end
  end
  // pins move only inside reset, so they are settled at capture
  // both lines of a port pulled high to disable it
  always @(posedge clk) begin
    if (!por_n || !ext_reset_n) begin
      held <= want;
    end
  end
  // glitch models later pin activity on the shared pins
  always_comb begin
    strap_in = glitch ? ~held : held;
    // unfitted resistors read as the weakest level
    if (EXT_FW) begin
      strap_in.nonrem_lvl = LVL_PD_WEAK;
      strap_in.charge_lvl = LVL_PD_WEAK;
    end
  end
endmodule : hscl_board_model
`default_nettype wire

// *** verification/hscl_strap_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module hscl_strap_config_tb;
  import hscl_pkg::*;
  localparam logic [5:0] LVL_MASK [8] = '{MASK_NONE, MASK_P1, MASK_P1_2, MASK_P1_3,
                                          MASK_P1_4, MASK_P1_6, MASK_NONE, MASK_NONE};
  logic        clk, rst_n, ext_reset_n, pulse, glitch, cfg_valid_ff;
  hscl_strap_s want, strap_in, s;
  hscl_cfg_s   cfg_ff, hold;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          n_errors, num_checks;

  hscl_strap_config i_dut (.clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .strap_in(strap_in),
    .cfg_ff(cfg_ff), .cfg_valid_ff(cfg_valid_ff), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  hscl_board_model i_board (.clk(clk), .por_n(rst_n), .pulse(pulse), .glitch(glitch), .want(want),
    .strap_in(strap_in), .ext_reset_n(ext_reset_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic hscl_cfg_s exp_cfg(input hscl_strap_s st, input logic [5:0] sw);
    hscl_cfg_s e;
    e.port_u2_dis = (st.dplus & st.dminus) | sw;
    e.port_u3_dis = e.port_u2_dis;
    e.nonrem_mask = LVL_MASK[st.nonrem_lvl];
    e.charge_mask = LVL_MASK[st.charge_lvl];
    e.mode        = st.mode;
    return e;
  endfunction : exp_cfg

  // bounded wait; no fixed latency assumed
  task automatic wait_valid();
    int n;
    n = 0;
    while (cfg_valid_ff !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (cfg_valid_ff !== 1'b1) begin
      n_errors++;
    end
  endtask : wait_valid

  // one edge between transfers so no handshake signal is assigned twice in a step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d    = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // external reset pulse, capture on its release
  task automatic recap(input hscl_strap_s st);
    want  <= st;
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(cfg_valid_ff), 32'h0000_0000);
    wait_valid();
  endtask : recap

  // long enough for every scenario below, with margin
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  initial begin
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    pulse = 1'b0;
    glitch = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    s = '{dplus: 6'h3F, dminus: 6'h35, nonrem_lvl: 3'h5, charge_lvl: 3'h2, mode: 3'h6};
    want = s;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_valid();
    chk(32'(cfg_ff), 32'(exp_cfg(s, 6'h00)));
    for (int i = 0; i < 8; i++) begin
      s = '{dplus: 6'h3F ^ 6'(i * 5), dminus: 6'(i * 11), nonrem_lvl: 3'(i), charge_lvl: 3'(7 - i),
            mode: 3'(i)};
      recap(s);
      chk(32'(cfg_ff), 32'(exp_cfg(s, 6'h00)));
    end
    axi_rd(REG_STRAP_PINS, rd, r);
    chk(rd, {10'h0, s.dplus & s.dminus, 2'h0, s.dminus, 2'h0, s.dplus});
    axi_rd(REG_FEATURES, rd, r);
    chk(rd, {13'h0, s.mode, 2'h0, LVL_MASK[s.charge_lvl], 2'h0, LVL_MASK[s.nonrem_lvl]});
    axi_rd(REG_STATUS, rd, r);
    chk(rd, 32'h0000_0001);
    hold = cfg_ff;
    glitch <= 1'b1;
    repeat (12) @(posedge clk);
    chk(32'(cfg_ff), 32'(hold));
    chk(32'(cfg_valid_ff), 32'h0000_0001);
    glitch <= 1'b0;
    axi_wr(REG_SW_DISABLE, 32'h0000_0030, r);
    chk(32'(r), 32'(RESP_OKAY));
    repeat (3) @(posedge clk);
    chk(32'(cfg_ff), 32'(exp_cfg(s, 6'h30)));
    axi_rd(REG_SW_DISABLE, rd, r);
    chk(rd, 32'h0000_0030);
    axi_wr(REG_FEATURES, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(REG_FEATURES, rd, r);
    chk(rd, {13'h0, s.mode, 2'h0, LVL_MASK[s.charge_lvl], 2'h0, LVL_MASK[s.nonrem_lvl]});
    axi_wr(8'h10, 32'h0000_0001, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h10, rd, r);
    chk({rd[29:0], r}, {30'h0, RESP_SLVERR});
    s = '{dplus: 6'h2A, dminus: 6'h2E, nonrem_lvl: 3'h1, charge_lvl: 3'h4, mode: 3'h1};
    want <= s;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wait_valid();
    chk(32'(cfg_ff), 32'(exp_cfg(s, SW_DIS_RST)));
    repeat (2) @(posedge clk);
    axi_rd(REG_SW_DISABLE, rd, r);
    chk(rd, 32'(SW_DIS_RST));
    stop_test();
  end
endmodule : hscl_strap_config_tb
`default_nettype wire
